// >>> dv/tcc_pin_model.sv
`timescale 1ns/100ps
// External signal source on both channel pins
module tcc_pin_model (
  input wire logic [1:0] ext_level,
  input wire logic [1:0] dut_out,
  input wire logic [1:0] dut_oe,
  output logic [1:0] pin
);
  // The outside world owns a pin whenever the timer lets go of it
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      pin[i] = dut_oe[i] ? dut_out[i] : ext_level[i];
    end
  end
endmodule : tcc_pin_model

// >>> dv/timer_capture_compare_pwm_tb.sv
`timescale 1ns/100ps
module timer_capture_compare_pwm_tb;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] counter = 16'h0000;
  logic [15:0] wd0 = 16'h0000, wd1 = 16'h0000;
  logic [1:0] ms0 = 2'h0, ms1 = 2'h0, els0 = 2'h0, els1 = 2'h0, ext = 2'h0;
  logic tick = 1'b0, ovf = 1'b0, tov0 = 1'b0, tov1 = 1'b0, ie0 = 1'b1, ie1 = 1'b0;
  logic clr0 = 1'b0, clr1 = 1'b0, wr0 = 1'b0, wr1 = 1'b0;
  logic [15:0] v0, v1, cap, v;
  logic [1:0] pin;
  logic f0, f1, q0, q1, po0, oe0, po1, oe1, link, act1, e, p;
  int seed = 63490;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;

  tcc_pin_model pm_u (.ext_level(ext), .dut_out({po1, po0}), .dut_oe({oe1, oe0}), .pin(pin));
  tcc_capture_compare dut_u (.clock(clock), .resetn(resetn), .counter(counter),
    .counter_tick(tick), .overflow(ovf), .ch0_mode_select(ms0), .ch1_mode_select(ms1),
    .ch0_edge_level_select(els0), .ch1_edge_level_select(els1),
    .ch0_toggle_on_overflow(tov0), .ch1_toggle_on_overflow(tov1),
    .ch0_int_enable(ie0), .ch1_int_enable(ie1), .ch0_flag_clear(clr0),
    .ch1_flag_clear(clr1), .ch0_value_write(wr0), .ch1_value_write(wr1),
    .ch0_value_wdata(wd0), .ch1_value_wdata(wd1), .first_channel_pin_in(pin[0]),
    .second_channel_pin_in(pin[1]), .ch0_value(v0), .ch1_value(v1),
    .ch0_event_flag(f0), .ch1_event_flag(f1), .ch0_irq(q0), .ch1_irq(q1),
    .first_channel_pin_out(po0), .first_channel_pin_oe(oe0),
    .second_channel_pin_out(po1), .second_channel_pin_oe(oe1),
    .channel_link_active(link), .second_channel_active(act1));

  always #10 clock = ~clock;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : finish_test

  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One counter tick, then the first pin is looked at once it has settled
  task automatic tk(input logic [15:0] c, input logic o, input logic ep);
    @(posedge clock);
    counter <= c;
    tick <= 1'b1;
    ovf <= o;
    @(posedge clock);
    tick <= 1'b0;
    ovf <= 1'b0;
    #1 chk("pin0", po0, ep);
  endtask : tk

  task automatic wv(input logic ch, input logic [15:0] d);
    @(posedge clock);
    wr0 <= !ch;
    wr1 <= ch;
    wd0 <= d;
    wd1 <= d;
    @(posedge clock);
    wr0 <= 1'b0;
    wr1 <= 1'b0;
  endtask : wv

  task automatic clear_flags;
    @(posedge clock);
    clr0 <= 1'b1;
    clr1 <= 1'b1;
    @(posedge clock);
    clr0 <= 1'b0;
    clr1 <= 1'b0;
  endtask : clear_flags

  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    #1 chk("rst", {f0, f1, q0, q1, po0, oe0, oe1, link, act1}, 16'h0000);
    // Capture on both channels, every edge code, rising and falling pin
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 2; j++) begin
        cap = 16'($random(seed));
        e = ext[0] ? k[1] : k[0];
        @(posedge clock);
        els0 <= k[1:0];
        els1 <= k[1:0];
        counter <= cap;
        ext <= {2{~ext[0]}};
        repeat (6) @(posedge clock);
        #1 chk("flag0", f0, e);
        chk("flag1", f1, e);
        chk("irq0", q0, e);
        chk("irq1", q1, 1'b0);
        chk("oe0", oe0, 1'b0);
        if (e) chk("cap0", v0, cap);
        if (e) chk("cap1", v1, cap);
        clear_flags();
      end
    end
    // Unbuffered compare: set, clear, toggle
    p = po0;
    ms0 <= 2'h1;
    for (int a = 3; a > 0; a--) begin
      v = 16'($random(seed)) | 16'h0010;
      els0 <= a[1:0];
      wv(1'b0, v);
      tk(v - 16'h0001, 1'b0, p);
      p = (a == 3) ? 1'b1 : (a == 2) ? 1'b0 : !p;
      tk(v, 1'b0, p);
      #1 chk("cmpflag", {f0, q0, oe0}, 16'h0007);
      clear_flags();
    end
    // Unbuffered PWM, high polarity, clear on compare
    tov0 <= 1'b1;
    els0 <= 2'h2;
    wv(1'b0, 16'h0080);
    tk(16'h0080, 1'b0, 1'b0);
    tk(16'h00ff, 1'b1, 1'b1);
    tk(16'h0080, 1'b0, 1'b0);
    tk(16'h00ff, 1'b1, 1'b1);
    // Unbuffered set on channel 1 with its interrupt enabled
    ms1 <= 2'h1;
    els1 <= 2'h3;
    ie1 <= 1'b1;
    wv(1'b1, 16'h0030);
    tk(16'h0030, 1'b0, 1'b1);
    chk("pin1", po1, 1'b1);
    chk("cmpflag1", {f1, q1, oe1}, 16'h0007);
    // Linked pair, low polarity; channel 1 control is junk on purpose
    ms0 <= 2'h3;
    ms1 <= 2'h1;
    els1 <= 2'h2;
    tov1 <= 1'b1;
    els0 <= 2'h3;
    wv(1'b0, 16'h0040);
    #1 chk("link", {link, act1, oe0, oe1}, 16'h000a);
    tk(16'h00ff, 1'b1, 1'b0);
    tk(16'h0040, 1'b0, 1'b1);
    tk(16'h00ff, 1'b1, 1'b0);
    wv(1'b1, 16'h0080);
    tk(16'h0080, 1'b0, 1'b0);
    tk(16'h00ff, 1'b1, 1'b1);
    @(posedge clock);
    #1 chk("act1", act1, 1'b1);
    tk(16'h00ff, 1'b1, 1'b0);
    tk(16'h0040, 1'b0, 1'b0);
    tk(16'h0080, 1'b0, 1'b1);
    wv(1'b0, 16'h0020);
    tk(16'h00ff, 1'b1, 1'b0);
    tk(16'h0020, 1'b0, 1'b1);
    #1 chk("act0", {act1, oe1, po1}, 16'h0001);
    finish_test();
  end
endmodule : timer_capture_compare_pwm_tb

// >>> include/tcc_cfg.svh
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
`define TCC_CNT_W 16
`define TCC_MODE_CAPTURE 2'h0
`define TCC_MODE_UNBUF 2'h1
`define TCC_EDGE_NONE 2'h0
`define TCC_EDGE_RISE 2'h1
`define TCC_EDGE_FALL 2'h2
`define TCC_EDGE_ANY 2'h3
`define TCC_ACT_TOGGLE 2'h1
`define TCC_ACT_CLEAR 2'h2
`define TCC_ACT_SET 2'h3
`define TCC_PIN_RESET 1'b0
`endif

// >>> include/tcc_pkg.sv
package tcc_pkg;
  typedef enum logic [1:0] {
    TCC_SRC_CH0,
    TCC_SRC_CH1
  } tcc_src_t;
endpackage : tcc_pkg

// >>> logic/tcc_capture_compare.sv
`timescale 1ns/100ps
`include "tcc_cfg.svh"
module tcc_capture_compare #(
  parameter int CNT_W = `TCC_CNT_W
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [CNT_W-1:0] counter,
  input wire logic counter_tick,
  input wire logic overflow,
  input wire logic [1:0] ch0_mode_select,
  input wire logic [1:0] ch1_mode_select,
  input wire logic [1:0] ch0_edge_level_select,
  input wire logic [1:0] ch1_edge_level_select,
  input wire logic ch0_toggle_on_overflow,
  input wire logic ch1_toggle_on_overflow,
  input wire logic ch0_int_enable,
  input wire logic ch1_int_enable,
  input wire logic ch0_flag_clear,
  input wire logic ch1_flag_clear,
  input wire logic ch0_value_write,
  input wire logic ch1_value_write,
  input wire logic [CNT_W-1:0] ch0_value_wdata,
  input wire logic [CNT_W-1:0] ch1_value_wdata,
  input wire logic first_channel_pin_in,
  input wire logic second_channel_pin_in,
  output logic [CNT_W-1:0] ch0_value,
  output logic [CNT_W-1:0] ch1_value,
  output logic ch0_event_flag,
  output logic ch1_event_flag,
  output logic ch0_irq,
  output logic ch1_irq,
  output logic first_channel_pin_out,
  output logic first_channel_pin_oe,
  output logic second_channel_pin_out,
  output logic second_channel_pin_oe,
  output logic channel_link_active,
  output logic second_channel_active
);
  logic [CNT_W-1:0] val0_reg, val0_next, val1_reg, val1_next;
  logic flag0_reg, flag0_next, flag1_reg, flag1_next;
  logic irq0_reg, irq0_next, irq1_reg, irq1_next;
  logic pin0_reg, pin0_next, pin1_reg, pin1_next;
  logic oe0_reg, oe0_next, oe1_reg, oe1_next;
  logic link_reg, link_next;
  logic act1_reg, act1_next;
  tcc_pkg::tcc_src_t act_reg, act_next, last_reg, last_next;
  logic link;
  logic cap0_mode, cap1_mode, cmp0_mode, cmp1_mode;
  logic [CNT_W-1:0] active_val;
  logic match0, match1;
  logic cap0_evt, cap1_evt;
  logic pin0_calc, pin1_calc;

  assign link = ch0_mode_select[1];
  assign cap0_mode = !link && ch0_mode_select == `TCC_MODE_CAPTURE;
  assign cap1_mode = !link && ch1_mode_select == `TCC_MODE_CAPTURE;
  assign cmp0_mode = link || ch0_mode_select[0];
  assign cmp1_mode = !link && ch1_mode_select != `TCC_MODE_CAPTURE;
  assign active_val = (link && act_reg == tcc_pkg::TCC_SRC_CH1) ? val1_reg : val0_reg;
  assign match0 = counter_tick && cmp0_mode && counter == active_val;
  assign match1 = counter_tick && cmp1_mode && counter == val1_reg;

  tcc_channel #(.CNT_W(CNT_W)) u_ch0 (
    .clock(clock),
    .resetn(resetn),
    .pin_in(first_channel_pin_in),
    .capture_mode(cap0_mode),
    .edge_level_select(ch0_edge_level_select),
    .match(match0),
    .overflow(overflow && counter_tick),
    .toggle_on_overflow(ch0_toggle_on_overflow),
    .drive_en(cmp0_mode),
    .pin_cur(pin0_reg),
    .capture_evt(cap0_evt),
    .pin_next(pin0_calc)
  );

  tcc_channel #(.CNT_W(CNT_W)) u_ch1 (
    .clock(clock),
    .resetn(resetn),
    .pin_in(second_channel_pin_in),
    .capture_mode(cap1_mode),
    .edge_level_select(ch1_edge_level_select),
    .match(match1),
    .overflow(overflow && counter_tick),
    .toggle_on_overflow(ch1_toggle_on_overflow),
    .drive_en(cmp1_mode),
    .pin_cur(pin1_reg),
    .capture_evt(cap1_evt),
    .pin_next(pin1_calc)
  );

  // Value pairs: a capture outranks a software write in the same cycle
  always_comb begin
    val0_next = val0_reg;
    val1_next = val1_reg;
    if (ch0_value_write) begin
      val0_next = ch0_value_wdata;
    end
    if (ch1_value_write) begin
      val1_next = ch1_value_wdata;
    end
    if (cap0_evt) begin
      val0_next = counter;
    end
    if (cap1_evt) begin
      val1_next = counter;
    end
  end

  // Link bookkeeping: source switches only on overflow
  always_comb begin
    link_next = link;
    act_next = act_reg;
    last_next = last_reg;
    if (!link) begin
      act_next = tcc_pkg::TCC_SRC_CH0;
      last_next = tcc_pkg::TCC_SRC_CH0;
    end else begin
      if (!link_reg) begin
        act_next = tcc_pkg::TCC_SRC_CH0;
        last_next = tcc_pkg::TCC_SRC_CH0;
      end
      if (ch0_value_write) begin
        last_next = tcc_pkg::TCC_SRC_CH0;
      end
      if (ch1_value_write) begin
        last_next = tcc_pkg::TCC_SRC_CH1;
      end
      if (overflow && counter_tick && link_reg) begin
        act_next = last_next;
      end
    end
  end

  // Flags set beats clear; interrupt requests are registered
  always_comb begin
    flag0_next = (flag0_reg && !ch0_flag_clear) || cap0_evt || match0;
    flag1_next = (flag1_reg && !ch1_flag_clear) || cap1_evt || match1;
    irq0_next = flag0_next && ch0_int_enable;
    irq1_next = flag1_next && ch1_int_enable;
    pin0_next = pin0_calc;
    pin1_next = link ? pin1_reg : pin1_calc;
    oe0_next = cmp0_mode;
    oe1_next = cmp1_mode;
    // Registered copy so the active-source output comes from a flip-flop
    act1_next = link_next && act_next == tcc_pkg::TCC_SRC_CH1;
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      val0_reg <= '0;
      val1_reg <= '0;
      flag0_reg <= 1'b0;
      flag1_reg <= 1'b0;
      irq0_reg <= 1'b0;
      irq1_reg <= 1'b0;
      pin0_reg <= `TCC_PIN_RESET;
      pin1_reg <= `TCC_PIN_RESET;
      oe0_reg <= 1'b0;
      oe1_reg <= 1'b0;
      link_reg <= 1'b0;
      act_reg <= tcc_pkg::TCC_SRC_CH0;
      last_reg <= tcc_pkg::TCC_SRC_CH0;
      act1_reg <= 1'b0;
    end else begin
      val0_reg <= val0_next;
      val1_reg <= val1_next;
      flag0_reg <= flag0_next;
      flag1_reg <= flag1_next;
      irq0_reg <= irq0_next;
      irq1_reg <= irq1_next;
      pin0_reg <= pin0_next;
      pin1_reg <= pin1_next;
      oe0_reg <= oe0_next;
      oe1_reg <= oe1_next;
      link_reg <= link_next;
      act_reg <= act_next;
      last_reg <= last_next;
      act1_reg <= act1_next;
    end
  end

  assign ch0_value = val0_reg;
  assign ch1_value = val1_reg;
  assign ch0_event_flag = flag0_reg;
  assign ch1_event_flag = flag1_reg;
  assign ch0_irq = irq0_reg;
  assign ch1_irq = irq1_reg;
  assign first_channel_pin_out = pin0_reg;
  assign first_channel_pin_oe = oe0_reg;
  assign second_channel_pin_out = pin1_reg;
  assign second_channel_pin_oe = oe1_reg;
  assign channel_link_active = link_reg;
  assign second_channel_active = act1_reg;

  // Capture, event flag, interrupt, pin action and link checks on both channels

  a_capture_copies: assert property (@(posedge clock) disable iff (!resetn)
    cap0_evt |=> val0_reg == $past(counter)) else $error("capture value wrong");
  a_flag_on_event: assert property (@(posedge clock) disable iff (!resetn)
    (cap1_evt || match1) |=> ch1_event_flag) else $error("flag not set");
  a_irq_gated: assert property (@(posedge clock) disable iff (!resetn)
    ch0_irq |-> ch0_event_flag) else $error("irq without flag");
  a_irq_enabled: assert property (@(posedge clock) disable iff (!resetn)
    (match0 && ch0_int_enable) |=> ch0_irq) else $error("irq missing");
  a_clear_on_match: assert property (@(posedge clock) disable iff (!resetn)
    (match0 && ch0_edge_level_select == `TCC_ACT_CLEAR) |=> !first_channel_pin_out)
    else $error("pin not cleared");
  a_set_on_match: assert property (@(posedge clock) disable iff (!resetn)
    (match1 && ch1_edge_level_select == `TCC_ACT_SET) |=> second_channel_pin_out)
    else $error("pin not set");
  a_ovf_toggle: assert property (@(posedge clock) disable iff (!resetn)
    (overflow && counter_tick && cmp0_mode && ch0_toggle_on_overflow && !match0)
    |=> first_channel_pin_out != $past(first_channel_pin_out))
    else $error("no overflow toggle");
  a_link_release: assert property (@(posedge clock) disable iff (!resetn)
    link |=> !second_channel_pin_oe) else $error("pin1 still driven");
  a_src_holds: assert property (@(posedge clock) disable iff (!resetn)
    (link_reg && link && !(overflow && counter_tick)) |=> $stable(act_reg))
    else $error("source switched mid period");
  a_first_link: assert property (@(posedge clock) disable iff (!resetn)
    $rose(link_reg) |-> act_reg == tcc_pkg::TCC_SRC_CH0) else $error("bad link start");
  a_capture_ch1: assert property (@(posedge clock) disable iff (!resetn)
    cap1_evt |=> val1_reg == $past(counter)) else $error("capture1 value wrong");
  a_flag0_on_match: assert property (@(posedge clock) disable iff (!resetn)
    match0 |=> ch0_event_flag) else $error("flag0 not set");
  a_flag_clear: assert property (@(posedge clock) disable iff (!resetn)
    (ch0_flag_clear && !cap0_evt && !match0) |=> !ch0_event_flag)
    else $error("flag0 not cleared");
  a_irq1_gated: assert property (@(posedge clock) disable iff (!resetn)
    ch1_irq |-> ch1_event_flag) else $error("irq1 without flag");

  // Pin action and output enable checks
  a_toggle_match: assert property (@(posedge clock) disable iff (!resetn)
    (match0 && ch0_edge_level_select == `TCC_ACT_TOGGLE && !(overflow && counter_tick))
    |=> first_channel_pin_out != $past(first_channel_pin_out))
    else $error("no compare toggle");
  a_oe_compare: assert property (@(posedge clock) disable iff (!resetn)
    cmp0_mode |=> first_channel_pin_oe) else $error("pin0 not driven");

  // Linked pair checks
  a_pin1_held: assert property (@(posedge clock) disable iff (!resetn)
    (link && link_reg) |=> $stable(second_channel_pin_out))
    else $error("pin1 moved while linked");
  a_src_at_ovf: assert property (@(posedge clock) disable iff (!resetn)
    (link && link_reg && overflow && counter_tick) |=> act_reg == $past(last_next))
    else $error("source not taken at overflow");

  c_capture: cover property (@(posedge clock) disable iff (!resetn) cap0_evt);
  c_capture1: cover property (@(posedge clock) disable iff (!resetn) cap1_evt);
  c_match1: cover property (@(posedge clock) disable iff (!resetn) match1);
  c_switch: cover property (@(posedge clock) disable iff (!resetn) $rose(second_channel_active));
  c_pwm_edge: cover property (@(posedge clock) disable iff (!resetn) match0 ##1 overflow);
endmodule : tcc_capture_compare

// >>> logic/tcc_channel.sv
`timescale 1ns/100ps
`include "tcc_cfg.svh"
// One channel: capture detection and compare action on the pin level
module tcc_channel #(
  parameter int CNT_W = `TCC_CNT_W
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic pin_in,
  input wire logic capture_mode,
  input wire logic [1:0] edge_level_select,
  input wire logic match,
  input wire logic overflow,
  input wire logic toggle_on_overflow,
  input wire logic drive_en,
  input wire logic pin_cur,
  output logic capture_evt,
  output logic pin_next
);
  logic rise;
  logic fall;

  tcc_edge_sync u_sync (
    .clock(clock),
    .resetn(resetn),
    .pin_in(pin_in),
    .rise(rise),
    .fall(fall)
  );

  always_comb begin
    capture_evt = 1'b0;
    if (capture_mode) begin
      unique case (edge_level_select)
        `TCC_EDGE_RISE: capture_evt = rise;
        `TCC_EDGE_FALL: capture_evt = fall;
        `TCC_EDGE_ANY: capture_evt = rise | fall;
        `TCC_EDGE_NONE: capture_evt = 1'b0;
      endcase
    end
  end

  // Overflow toggle first, then the compare action on top: set and clear win, a compare toggle undoes it
  always_comb begin
    pin_next = pin_cur;
    if (drive_en) begin
      if (overflow && toggle_on_overflow) begin
        pin_next = ~pin_cur;
      end
      if (match) begin
        unique case (edge_level_select)
          `TCC_ACT_TOGGLE: pin_next = ~pin_next;
          `TCC_ACT_CLEAR: pin_next = 1'b0;
          `TCC_ACT_SET: pin_next = 1'b1;
          `TCC_EDGE_NONE: pin_next = pin_next;
        endcase
      end
    end
  end
endmodule : tcc_channel

// >>> logic/tcc_edge_sync.sv
`timescale 1ns/100ps
// Three-stage pin synchroniser with edge detection on the last two stages
module tcc_edge_sync (
  input wire logic clock,
  input wire logic resetn,
  input wire logic pin_in,
  output logic rise,
  output logic fall
);
  logic [2:0] sync_reg;
  logic [2:0] sync_next;

  always_comb begin
    sync_next = {sync_reg[1:0], pin_in};
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      sync_reg <= 3'h0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign rise = sync_reg[1] & ~sync_reg[2];
  assign fall = ~sync_reg[1] & sync_reg[2];
endmodule : tcc_edge_sync
